// ### include/adcs_consts.svh
// register map, field positions, reserved-bit value and state counts
// What this block does
// - trigger control bit 7 enables pin start; edge polarity from edge register.
// - trigger control bits 6..1 ignore writes and read as ones.
// - each result is a 10-bit successive approximation code; single or scan.
// - one write may set start and new mode or channel together.
// - single mode converts the chosen channel once into its data register.
// - single end sets end flag; interrupt raised when enabled.
// - single mode start reads one during conversion, clears itself at end.
// - scan start begins at channel 0 of the group.
// - scan converts group channels in order, each into its own register.
// - scan group end sets flag, interrupt if enabled, restarts at channel 0.
// - scan never clears start; stops when software clears it.
// - start delay then sampling: 31 states slow, 15 states fast.
// - first conversion totals 131..134 states slow, 69..70 fast.
// - later scan conversions take exactly 128 slow or 66 fast states.
// - enabled pin edge sets start; the rest is as a software start.
// - end flag clears only by writing 0 after reading it as 1.
// - status bit 4 picks scan mode, reset 0.
// - low two channel bits pick channel or scan group 0..n; top ignored.
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH
// ==========================================================================
// register word indexes
`define ADCS_IDX_CSR   3'h0
`define ADCS_IDX_TRG   3'h1
`define ADCS_IDX_EDGE  3'h2
`define ADCS_IDX_DATA  1'h1
// ==========================================================================
// field positions
`define ADCS_B_FLAG    7
`define ADCS_B_IRQEN   6
`define ADCS_B_START   5
`define ADCS_B_SCAN    4
`define ADCS_B_SPEED   3
`define ADCS_B_TRGEN   7
`define ADCS_B_EDGE    5
`define ADCS_TRG_ONES  6'h3F
// ==========================================================================
// state counts
`define ADCS_SAMPLE_SLOW 7'h1F
`define ADCS_SAMPLE_FAST 7'h0F
`define ADCS_CONV_SLOW   7'h5E
`define ADCS_CONV_FAST   7'h30
`define ADCS_STEP_SLOW   4'h9
`define ADCS_STEP_FAST   4'h4
`define ADCS_DLY_BASE    7'h03
`define ADCS_DLY_SCAN    7'h01
`endif

// ### include/adcs_pkg.sv
// types shared by the sequencer and the conversion core
package adcs_pkg;
  typedef enum {ST_IDLE, ST_CONV} adcs_ctl_e;
  typedef enum {C_IDLE, C_DELAY, C_SAMPLE, C_CONV} adcs_core_e;
  typedef logic [9:0] adcs_code_t;
endpackage

// ### include/adcs_conv_if.sv
// link between the sequencer and the conversion core
`timescale 1ns/10ps
interface adcs_conv_if;
  import adcs_pkg::*;
  logic       go;
  logic       abort;
  logic       speed;
  logic [6:0] delay;
  logic       done;
  adcs_code_t result;
  modport ctl  (output go, abort, speed, delay, input done, result);
  modport core (input go, abort, speed, delay, output done, result);
endinterface

// ### verilog/adcs_sar_core.sv
// delay, sample and successive approximation engine
`timescale 1ns/10ps
`include "adcs_consts.svh"
module adcs_sar_core
(
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire logic          cmp_low_i,
  output adcs_pkg::adcs_code_t trial_o,
  output logic               sample_o,
  adcs_conv_if.core          cv
);
  import adcs_pkg::*;

  adcs_core_e st;
  logic [6:0] cnt;
  logic [3:0] step;
  logic [3:0] bitn;

  // ========================================================================
  // one trial: drop the bit when input is below, set the next one
  function automatic adcs_code_t sar_next(adcs_code_t c, logic [3:0] b,
                                          logic low);
    adcs_code_t n;
    n = c;
    if (low)
      n[b] = 1'h0;
    if (b != 4'h0)
      n[b - 4'h1] = 1'h1;
    return n;
  endfunction

  // ========================================================================
  // sequencing
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || cv.abort)
    begin
      st       <= C_IDLE;
      cnt      <= 7'h00;
      step     <= 4'h0;
      bitn     <= 4'h0;
      trial_o  <= 10'h000;
      sample_o <= 1'h0;
      cv.done  <= 1'h0;
    end
    else
    begin
      cv.done <= 1'h0;
      case (st)
        C_IDLE:
          if (cv.go)
          begin
            st  <= C_DELAY;
            cnt <= cv.delay;
          end
        C_DELAY:
          if (cnt == 7'h01)
          begin
            st       <= C_SAMPLE;
            sample_o <= 1'h1;
            cnt      <= cv.speed ? `ADCS_SAMPLE_FAST : `ADCS_SAMPLE_SLOW;
          end
          else
            cnt <= cnt - 7'h01;
        C_SAMPLE:
          if (cnt == 7'h01)
          begin
            st       <= C_CONV;
            sample_o <= 1'h0;
            cnt      <= cv.speed ? `ADCS_CONV_FAST : `ADCS_CONV_SLOW;
            step     <= cv.speed ? `ADCS_STEP_FAST : `ADCS_STEP_SLOW;
            bitn     <= 4'h9;
            trial_o  <= 10'h200;
          end
          else
            cnt <= cnt - 7'h01;
        C_CONV:
        begin
          step <= step - 4'h1;
          if (step == 4'h1 && bitn != 4'hF)
          begin
            trial_o <= sar_next(trial_o, bitn, cmp_low_i);
            bitn    <= bitn - 4'h1;
            step    <= cv.speed ? `ADCS_STEP_FAST : `ADCS_STEP_SLOW;
          end
          if (cnt == 7'h01)
          begin
            st      <= C_IDLE;
            cv.done <= 1'h1;
          end
          else
            cnt <= cnt - 7'h01;
        end
        default:
          st <= C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      cv.result <= 10'h000;
    else if (st == C_CONV && cnt == 7'h01)
      cv.result <= trial_o;
  end

  // ========================================================================
  // checks
  property p_sample_fast;
    @(posedge clk_i) disable iff (!rstn_i || cv.abort)
    $rose(sample_o) && cv.speed |-> ##14 sample_o ##1 !sample_o;
  endproperty
  a_sample_fast: assert property (p_sample_fast)
    else $error("fast sampling not 15 states");

  property p_sample_slow;
    @(posedge clk_i) disable iff (!rstn_i || cv.abort)
    $rose(sample_o) && !cv.speed |-> ##30 sample_o ##1 !sample_o;
  endproperty
  a_sample_slow: assert property (p_sample_slow)
    else $error("slow sampling not 31 states");
endmodule

// ### verilog/adcs_top.sv
// conversion sequencer with register slave and trigger input
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "adcs_consts.svh"
module adcs_top
(
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  input  wire logic [2:0]      avs_address_i,
  input  wire logic            avs_read_i,
  input  wire logic            avs_write_i,
  input  wire logic [31:0]     avs_writedata_i,
  input  wire logic [3:0]      avs_byteenable_i,
  output logic [31:0]          avs_readdata_o,
  output logic                 avs_waitrequest_o,
  input  wire logic            ext_trigger_pin_i,
  input  wire logic            cmp_low_i,
  output logic                 conversion_end_irq_o,
  output logic                 sample_hold_o,
  output adcs_pkg::adcs_code_t trial_code_o,
  output logic [1:0]           chan_sel_o
);
  import adcs_pkg::*;

  adcs_conv_if cv ();

  logic       conversion_end_flag;
  logic       conversion_end_irq_enable;
  logic       conversion_start;
  logic       scan_mode;
  logic       conversion_speed_select;
  logic [2:0] chan_sel;
  logic       trigger_enable;
  logic       trg_res0;
  logic       trigger_edge_select;
  logic       flag_seen;
  adcs_code_t result_mem [0:3];
  adcs_ctl_e  st;
  logic [1:0] cur_ch;
  logic [1:0] phase;
  logic       trg_s1;
  logic       trg_s2;
  logic       trg_s3;
  logic       cmp_s1;
  logic       cmp_s2;
  logic       wr_en;
  logic       rd_ack;
  logic       wr_csr;
  logic [7:0] wd;
  logic       trig_fire;
  logic       end_evt;
  logic       last_ch;
  logic       set_flag;
  logic [31:0] rd_word;

  // ========================================================================
  // bus decode: a request is taken at the edge where waitrequest is low
  assign wd      = avs_writedata_i[7:0];
  assign wr_en   = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign rd_ack  = avs_read_i && !avs_waitrequest_o;
  assign wr_csr  = wr_en && avs_address_i == `ADCS_IDX_CSR;
  assign end_evt = st == ST_CONV && cv.done && conversion_start;
  assign last_ch = cur_ch == chan_sel[1:0];
  assign set_flag = end_evt && (!scan_mode || last_ch);
  assign trig_fire = trigger_enable &&
                     (trigger_edge_select ? (trg_s2 && !trg_s3)
                                          : (!trg_s2 && trg_s3));

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      avs_waitrequest_o <= 1'h1;
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
      avs_waitrequest_o <= 1'h0;
    else
      avs_waitrequest_o <= 1'h1;
  end

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (avs_address_i)
      `ADCS_IDX_CSR:
        rd_word[7:0] = {conversion_end_flag, conversion_end_irq_enable,
                        conversion_start, scan_mode,
                        conversion_speed_select, chan_sel};
      `ADCS_IDX_TRG:
        rd_word[7:0] = {trigger_enable, `ADCS_TRG_ONES, trg_res0};
      `ADCS_IDX_EDGE:
        rd_word[`ADCS_B_EDGE] = trigger_edge_select;
      default:
        if (avs_address_i[2] == `ADCS_IDX_DATA)
          rd_word[9:0] = result_mem[avs_address_i[1:0]];
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && avs_waitrequest_o)
      avs_readdata_o <= rd_word;
  end

  // ========================================================================
  // control registers
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      conversion_end_irq_enable <= 1'h0;
      scan_mode                 <= 1'h0;
      conversion_speed_select   <= 1'h0;
      chan_sel                  <= 3'h0;
    end
    else if (wr_csr)
    begin
      conversion_end_irq_enable <= wd[`ADCS_B_IRQEN];
      scan_mode                 <= wd[`ADCS_B_SCAN];
      conversion_speed_select   <= wd[`ADCS_B_SPEED];
      chan_sel                  <= wd[2:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      trigger_enable      <= 1'h0;
      trg_res0            <= 1'h0;
      trigger_edge_select <= 1'h0;
    end
    else if (wr_en && avs_address_i == `ADCS_IDX_TRG)
    begin
      trigger_enable <= wd[`ADCS_B_TRGEN];
      trg_res0       <= wd[0];
    end
    else if (wr_en && avs_address_i == `ADCS_IDX_EDGE)
      trigger_edge_select <= wd[`ADCS_B_EDGE];
  end

  // start: pin edge wins, then software, then the single-mode self clear
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      conversion_start <= 1'h0;
    else if (trig_fire)
      conversion_start <= 1'h1;
    else if (wr_csr)
      conversion_start <= wd[`ADCS_B_START];
    else if (end_evt && !scan_mode)
      conversion_start <= 1'h0;
  end

  // end flag: set wins; cleared by a 0 write only after it was read as 1
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      flag_seen <= 1'h0;
    else if (rd_ack && avs_address_i == `ADCS_IDX_CSR &&
             avs_readdata_o[`ADCS_B_FLAG])
      flag_seen <= 1'h1;
    else if (wr_csr)
      flag_seen <= 1'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      conversion_end_flag <= 1'h0;
    else if (set_flag)
      conversion_end_flag <= 1'h1;
    else if (wr_csr && !wd[`ADCS_B_FLAG] && flag_seen)
      conversion_end_flag <= 1'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      conversion_end_irq_o <= 1'h0;
    else
      conversion_end_irq_o <= conversion_end_flag &&
                              conversion_end_irq_enable;
  end

  // ========================================================================
  // pin synchronisers and start phase divider
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      trg_s1 <= 1'h1;
      trg_s2 <= 1'h1;
      trg_s3 <= 1'h1;
      cmp_s1 <= 1'h0;
      cmp_s2 <= 1'h0;
    end
    else
    begin
      trg_s1 <= ext_trigger_pin_i;
      trg_s2 <= trg_s1;
      trg_s3 <= trg_s2;
      cmp_s1 <= cmp_low_i;
      cmp_s2 <= cmp_s1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end

  // ========================================================================
  // sequencer
  assign cv.speed = conversion_speed_select;
  assign cv.abort = st == ST_CONV && !conversion_start;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st       <= ST_IDLE;
      cur_ch   <= 2'h0;
      cv.go    <= 1'h0;
      cv.delay <= 7'h00;
    end
    else
    begin
      cv.go <= 1'h0;
      case (st)
        ST_IDLE:
          if (conversion_start)
          begin
            st       <= ST_CONV;
            cv.go    <= 1'h1;
            cur_ch   <= scan_mode ? 2'h0 : chan_sel[1:0];
            cv.delay <= `ADCS_DLY_BASE + (conversion_speed_select ?
                        {6'h00, ~phase[0]} : {5'h00, ~phase});
          end
        ST_CONV:
          if (!conversion_start)
            st <= ST_IDLE;
          else if (cv.done)
          begin
            if (!scan_mode)
              st <= ST_IDLE;
            else
            begin
              cv.go    <= 1'h1;
              cv.delay <= `ADCS_DLY_SCAN;
              cur_ch   <= last_ch ? 2'h0 : cur_ch + 2'h1;
            end
          end
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      chan_sel_o <= 2'h0;
    else
      chan_sel_o <= cur_ch;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 4; i++)
        result_mem[i] <= 10'h000;
    end
    else if (end_evt)
      result_mem[cur_ch] <= cv.result;
  end

  adcs_sar_core u_core
  (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .cmp_low_i (cmp_s2),
    .trial_o   (trial_code_o),
    .sample_o  (sample_hold_o),
    .cv        (cv.core)
  );

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_scan_end;
    end_evt && scan_mode;
  endsequence

  property p_res_ones;
    rd_ack && avs_address_i == `ADCS_IDX_TRG |-> avs_readdata_o[6:1] == 6'h3F;
  endproperty
  a_res_ones: assert property (p_res_ones)
    else $error("reserved trigger bits not ones");

  property p_single_end;
    end_evt && !scan_mode && !trig_fire && !wr_csr
      |=> !conversion_start && conversion_end_flag && st == ST_IDLE;
  endproperty
  a_single_end: assert property (p_single_end)
    else $error("single end did not clear start and set flag");

  property p_scan_go;
    s_scan_end and (!wr_csr) |=> conversion_start && cv.go;
  endproperty
  a_scan_go: assert property (p_scan_go)
    else $error("scan did not continue");

  property p_scan_wrap;
    s_scan_end and (last_ch) |=> conversion_end_flag && cur_ch == 2'h0;
  endproperty
  a_scan_wrap: assert property (p_scan_wrap)
    else $error("scan group end wrong");

  property p_pin_fall;
    trigger_enable && !trigger_edge_select && trg_s3 && !trg_s2
      |=> conversion_start;
  endproperty
  a_pin_fall: assert property (p_pin_fall)
    else $error("pin edge did not set start");

  property p_scan_slow;
    s_scan_end and (!conversion_speed_select)
      |-> ##128 (cv.done || st == ST_IDLE);
  endproperty
  a_scan_slow: assert property (p_scan_slow)
    else $error("scan period not 128");

  property p_scan_fast;
    s_scan_end and (conversion_speed_select)
      |-> ##66 (cv.done || st == ST_IDLE);
  endproperty
  a_scan_fast: assert property (p_scan_fast)
    else $error("scan period not 66");

  property p_first_slow;
    st == ST_IDLE && conversion_start && !conversion_speed_select
      |-> ##[130:133] (cv.done || st == ST_IDLE);
  endproperty
  a_first_slow: assert property (p_first_slow)
    else $error("first conversion out of 131..134");

  property p_store;
    end_evt |=> result_mem[$past(cur_ch)] == $past(cv.result);
  endproperty
  a_store: assert property (p_store)
    else $error("result not stored");

  property p_flag_clear;
    $fell(conversion_end_flag) |-> $past(flag_seen);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag cleared without prior read");
endmodule

// ### sim/adcs_analog_model.sv
// analog input and comparator model for the conversion core
`timescale 1ns/10ps
module adcs_analog_model
(
  input  wire logic                 clk_i,
  input  wire logic [39:0]          levels_i,
  input  wire logic [1:0]           chan_sel_i,
  input  wire logic                 sample_i,
  input  wire adcs_pkg::adcs_code_t trial_i,
  output logic                      cmp_low_o
);
  import adcs_pkg::*;
  // ========================================================================
  // sample and hold, then compare against the trial code
  adcs_code_t held;
  initial held = 10'h000;
  always @(posedge clk_i)
  begin
    if (sample_i)
      held <= levels_i[chan_sel_i*10 +: 10];
  end
  // held level below trial gives 1; the code settles on the level
  assign cmp_low_o = (held < trial_i);
endmodule

// ### sim/adcs_tb_top.sv
// self-checking testbench of the conversion sequencer
`timescale 1ns/10ps
module adcs_tb_top;
  import adcs_pkg::*;
  // ========================================================================
  // signals
  logic        clk_i, rstn_i, avs_read_i, avs_write_i;
  logic [2:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic        avs_waitrequest_o, ext_trigger_pin_i, cmp_low_i;
  logic        conversion_end_irq_o, sample_hold_o;
  adcs_code_t  trial_code_o;
  logic [1:0]  chan_sel_o;
  logic [39:0] levels;
  adcs_code_t  lv [4];
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  int          miscompares, comparisons;
  // ========================================================================
  // design and far side
  adcs_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ext_trigger_pin_i(ext_trigger_pin_i), .cmp_low_i(cmp_low_i),
    .conversion_end_irq_o(conversion_end_irq_o),
    .sample_hold_o(sample_hold_o), .trial_code_o(trial_code_o),
    .chan_sel_o(chan_sel_o));
  adcs_analog_model model (.clk_i(clk_i), .levels_i(levels),
    .chan_sel_i(chan_sel_o), .sample_i(sample_hold_o),
    .trial_i(trial_code_o), .cmp_low_o(cmp_low_i));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ========================================================================
  // checking and closing
  task automatic chk(input logic [31:0] got, exp, msk, input string what);
    comparisons++;
    if ((got & msk) !== (exp & msk))
    begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic timeout(input string what);
    miscompares++;
    $display("mismatch at %0t: wait for %s ran out", $time, what);
    complete_run();
  endtask
  // read results come off the queue as the slave answers
  always @(posedge clk_i)
  begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
    begin
      if (exp_q.size() == 0)
        timeout("read note");
      else
        chk(avs_readdata_o, exp_q.pop_front(), msk_q.pop_front(), "read");
    end
  end
  // ========================================================================
  // bus tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] d,
                    input logic [3:0] be = 4'hF);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_byteenable_i <= be;
    avs_write_i     <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    avs_write_i <= 1'b0;
    if (n == 50)
      timeout("write");
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e, m);
    int n;
    n = 0;
    @(posedge clk_i);
    exp_q.push_back(e);
    msk_q.push_back(m);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    avs_read_i <= 1'b0;
    if (n == 50)
      timeout("read");
  endtask
  // ========================================================================
  // timing helpers
  task automatic lat(input int lo, hi);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (conversion_end_irq_o !== 1'b1 && n < 400);
    if (n == 400)
      timeout("conversion end");
    chk(n >= lo && n <= hi, 1, 1, "conversion time");
  endtask
  task automatic quiet(input int cyc);
    int bad;
    bad = 0;
    repeat (cyc)
    begin
      @(posedge clk_i);
      if (sample_hold_o !== 1'b0)
        bad++;
    end
    chk(bad, 0, 32'hFFFFFFFF, "no sampling");
  endtask
  task automatic scanw(input int per, g);
    int t, last, k;
    logic pv;
    t = 0;
    k = 0;
    last = 0;
    pv = sample_hold_o;
    while (k <= 2 * g && t < 2000)
    begin
      @(posedge clk_i);
      t++;
      if (sample_hold_o === 1'b1 && pv !== 1'b1)
      begin
        chk(chan_sel_o, k % g, 3, "scan channel");
        if (k >= 2)
          chk(t - last, per, 32'hFFFFFFFF, "scan period");
        last = t;
        k++;
      end
      pv = sample_hold_o;
    end
    if (t == 2000)
      timeout("scan");
  endtask
  task automatic newlv;
    for (int i = 0; i < 4; i++)
      lv[i] = 10'($urandom);
    levels <= {lv[3], lv[2], lv[1], lv[0]};
  endtask
  // ========================================================================
  // main sequence
  initial
  begin
    logic [2:0] ch;
    logic       s;
    rstn_i = 1'b0;
    avs_address_i = 3'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000;
    avs_byteenable_i = 4'hF;
    ext_trigger_pin_i = 1'b1;
    levels = 40'h0000000000;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(81074));
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(3'h0, 32'h00, 32'hFFFFFFFF);
    rd(3'h1, 32'h7E, 32'hFFFFFFFF);
    rd(3'h2, 32'h00, 32'hFFFFFFFF);
    rd(3'h3, 32'h00, 32'hFFFFFFFF);
    wr(3'h1, 8'hFE);
    rd(3'h1, 32'hFE, 32'hFFFFFFFF);
    wr(3'h1, 8'h00);
    rd(3'h1, 32'h7E, 32'hFFFFFFFF);
    wr(3'h1, 8'h80, 4'h0);
    rd(3'h1, 32'h7E, 32'hFFFFFFFF);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      s = i[1];
      ch = 3'($urandom % 8);
      newlv();
      wr(3'h0, 8'h60 | {4'h0, s, ch});
      if (s)
        lat(71, 72);
      else
        lat(133, 136);
      wr(3'h0, 8'h40 | {4'h0, s, ch});
      rd(3'h0, 8'hC0 | {4'h0, s, ch}, 32'hFF);
      wr(3'h0, 8'h00);
      rd(3'h0, 32'h00, 32'hFF);
      wr({1'b1, ch[1:0]}, 8'h00);
      rd({1'b1, ch[1:0]}, lv[ch[1:0]], 32'hFFFFFFFF);
    end
    $display("test single done");
    for (int i = 0; i < 2; i++)
    begin
      s = i[0];
      newlv();
      wr(3'h0, 8'h70 | {4'h0, s, 1'b1, ~s, 1'b1});
      scanw(s ? 66 : 128, s ? 2 : 4);
      rd(3'h0, 32'hB0 | {28'h0, s, 3'h0}, 32'hB8);
      wr(3'h0, 8'h50 | {4'h0, s, 1'b1, ~s, 1'b1});
      repeat (4) @(posedge clk_i);
      quiet(300);
      for (int c = 0; c < (s ? 2 : 4); c++)
        rd(3'(4 + c), lv[c], 32'hFFFFFFFF);
      rd(3'h0, 8'h50 | {4'h0, s, 1'b1, ~s, 1'b1}, 32'hFF);
      wr(3'h0, 8'h00);
    end
    $display("test scan done");
    for (int i = 0; i < 2; i++)
    begin
      s = i[0];
      ch = 3'($urandom % 4);
      newlv();
      ext_trigger_pin_i <= ~s;
      wr(3'h2, {2'h0, s, 5'h00});
      wr(3'h0, 8'h40 | {5'h00, ch});
      wr(3'h1, 8'h80);
      repeat (4) @(posedge clk_i);
      ext_trigger_pin_i <= s;
      lat(133, 142);
      rd(3'h0, 8'hC0 | {5'h00, ch}, 32'hFF);
      wr(3'h0, 8'h00);
      rd({1'b1, ch[1:0]}, lv[ch[1:0]], 32'hFFFFFFFF);
      wr(3'h1, 8'h00);
      ext_trigger_pin_i <= ~s;
      repeat (4) @(posedge clk_i);
      ext_trigger_pin_i <= s;
      quiet(60);
    end
    $display("test trigger done");
    complete_run();
  end
endmodule
